// ==== core/nand_host_params.svh ====
/*
  timing counts, commands and marker positions for the nand host controller.
  assumes a 250 MHz mclk_i.
*/
`ifndef NAND_HOST_PARAMS_SVH
`define NAND_HOST_PARAMS_SVH

`define CLK_PERIOD_PS 4000
`define CMD_FIRST_AREA 8'h00
`define CMD_SECOND_HALF 8'h01
`define CMD_SPARE_AREA 8'h50
`define CMD_PROG_LOAD 8'h80
`define CMD_PROG_START 8'h10
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_START 8'hD0
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hFF
`define ERASED_BYTE 8'hFF
`define MARK_COL_X8 4'h5
`define STROBE_TIME_PS 60000
`define STROBE_CYCLES ((`STROBE_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WE_HIGH_TO_OUT_TIME_PS 60000
`define WE_HIGH_TO_OUT_CYCLES ((`WE_HIGH_TO_OUT_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DESELECT_HOLD_TIME_PS 100000
`define DESELECT_HOLD_CYCLES ((`DESELECT_HOLD_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS + 1)
`define LAST_OUT_TO_BUSY_TIME_PS 100000
`define LAST_OUT_TO_BUSY_CYCLES ((`LAST_OUT_TO_BUSY_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CELL_LOAD_TIME_US 12
`define CELL_LOAD_CYCLES ((`CELL_LOAD_TIME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== core/nand_host_pkg.sv ====
/*
  types of the nand host controller.
  assumes nothing beyond the params header.
*/
package nand_host_pkg;
  typedef enum logic [1:0] {
    area_first_type = 2'h0,
    area_second_type = 2'h1,
    area_spare_type = 2'h2
  } area_type;

  typedef enum logic [2:0] {
    op_read_type = 3'h0,
    op_program_type = 3'h1,
    op_erase_type = 3'h2,
    op_reset_type = 3'h3,
    op_scan_type = 3'h4
  } op_type;
endpackage

// ==== core/bad_block_table.sv ====
/*
  invalid block table: one flag per physical block plus a mapping lookup.
  assumes the controller marks blocks and looks them up on the same clock.
*/
module bad_block_table #(
  parameter int BLOCKS = 4096,
  parameter int ABITS = 12
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic mark_i,
  input wire logic [ABITS-1:0] mark_addr_i,
  input wire logic [ABITS-1:0] look_addr_i,
  output logic look_bad_o
);
  logic [BLOCKS-1:0] bad_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      bad_reg <= '0;
    end else if (mark_i) begin
      bad_reg[mark_addr_i] <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      look_bad_o <= 1'b0;
    end else begin
      look_bad_o <= bad_reg[look_addr_i];
    end
  end
endmodule // bad_block_table

// ==== core/nand_host.sv ====
/*
  host controller for an asynchronous byte-wide nand flash: command, address
  and data strobes, pointer tracking, invalid-block scan and lookup.
  assumes the flash pins are asynchronous and the user holds requests until
  done_o.
*/
`include "nand_host_params.svh"

// Function
// - issue 00h or 50h before 80h
// - issue 01h right before 80h
// - hold chip select high over 100 ns
// - scan markers before any erase
// - map out invalid blocks; the scan never lists block 0, and only erases of listed blocks are refused
// - failed status retires block
// - reads need error correction; rdata_o is the raw byte with none applied
// - replacement rewrites failed page first; the controller only marks the block in the table
// - page read is 00h plus four addresses
module nand_host
  import nand_host_pkg::*;
#(
  parameter int ABITS = 12,
  parameter int CELL_LOAD_CYCLES = `CELL_LOAD_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire nand_host_pkg::op_type op_i,
  input wire nand_host_pkg::area_type area_i,
  input wire logic [ABITS-1:0] block_i,
  input wire logic [4:0] page_i,
  input wire logic [7:0] column_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] io_in_i,
  input wire logic ready_busy_i,
  output logic [7:0] io_out_o,
  output logic io_oe_o,
  output logic cle_o,
  output logic ale_o,
  output logic chip_sel_n_o,
  output logic write_strobe_n_o,
  output logic output_strobe_n_o,
  output logic [7:0] rdata_o,
  output logic done_o,
  output logic fail_o,
  output logic block_bad_o,
  output logic scan_done_o,
  output nand_host_pkg::area_type pointer_o
);
  import nand_host_pkg::*;

  // ==========================================================
  // states
  typedef enum logic [9:0] {
    st_idle_type = 10'h001, st_ptr_type = 10'h002, st_cmd_type = 10'h004, st_addr_type = 10'h008,
    st_data_type = 10'h010, st_cmd2_type = 10'h020, st_wait_type = 10'h040, st_stat_type = 10'h080,
    st_read_type = 10'h100, st_desel_type = 10'h200
  } state_type;

  state_type state_reg;
  op_type op_reg;
  area_type area_reg;
  logic [7:0] sync1_reg, sync2_reg;
  logic rb1_reg, rb2_reg;
  logic [15:0] tick_reg;
  logic [2:0] addr_cnt_reg;
  logic [ABITS-1:0] block_reg;
  logic [4:0] page_reg;
  logic [7:0] col_reg;
  logic [7:0] wdata_reg;
  logic scanned_reg;
  logic [ABITS-1:0] scan_blk_reg;
  logic scan_page_reg;
  logic mark_reg;
  logic look_bad;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= 8'h00; sync2_reg <= 8'h00; rb1_reg <= 1'b0; rb2_reg <= 1'b0;
    end else begin
      sync1_reg <= io_in_i; sync2_reg <= sync1_reg; rb1_reg <= ready_busy_i; rb2_reg <= rb1_reg;
    end
  end

  // ==========================================================
  // invalid block table
  bad_block_table #(.BLOCKS(1 << ABITS), .ABITS(ABITS)) u_table (
    .mclk_i(mclk_i), .rst_i(rst_i), .mark_i(mark_reg), .mark_addr_i(scan_blk_reg),
    .look_addr_i(block_i), .look_bad_o(look_bad)
  );

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      block_bad_o <= 1'b0;
    end else begin
      block_bad_o <= look_bad;
    end
  end

  // ==========================================================
  // byte presented in each phase
  function automatic logic [7:0] addr_byte(input logic [2:0] n, input logic [7:0] c,
                                           input logic [4:0] p, input logic [ABITS-1:0] b);
    logic [31:0] row;
    row = {{(27-ABITS){1'b0}}, b, p};
    case (n)
      3'h0: addr_byte = c;
      3'h1: addr_byte = row[7:0];
      3'h2: addr_byte = row[15:8];
      default: addr_byte = row[23:16];
    endcase
  endfunction

  function automatic logic [7:0] op_cmd(input op_type o);
    case (o)
      op_program_type: op_cmd = `CMD_PROG_LOAD;
      op_erase_type: op_cmd = `CMD_ERASE_SETUP;
      op_reset_type: op_cmd = `CMD_RESET;
      default: op_cmd = `CMD_FIRST_AREA;
    endcase
  endfunction

  function automatic logic [7:0] ptr_cmd(input area_type a);
    case (a)
      area_second_type: ptr_cmd = `CMD_SECOND_HALF;
      area_spare_type: ptr_cmd = `CMD_SPARE_AREA;
      default: ptr_cmd = `CMD_FIRST_AREA;
    endcase
  endfunction

  // ==========================================================
  // sequencer; each command, address and data phase is one strobe period of STROBE_CYCLES, status and read take two
  logic phase_end;
  assign phase_end = (tick_reg == 16'(`STROBE_CYCLES - 1));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= st_idle_type; op_reg <= op_read_type; area_reg <= area_first_type;
      tick_reg <= 16'h0000; addr_cnt_reg <= 3'h0; block_reg <= '0; page_reg <= 5'h00;
      col_reg <= 8'h00; wdata_reg <= 8'h00; done_o <= 1'b0; fail_o <= 1'b0; rdata_o <= 8'h00;
      scanned_reg <= 1'b0; scan_blk_reg <= '0; scan_page_reg <= 1'b0; mark_reg <= 1'b0;
      scan_done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      mark_reg <= 1'b0;
      tick_reg <= tick_reg + 16'h0001;
      case (state_reg)
        st_idle_type: begin
          tick_reg <= 16'h0000;
          if (!scanned_reg && rb2_reg) begin
            op_reg <= op_scan_type; area_reg <= area_spare_type; col_reg <= 8'(`MARK_COL_X8);
            block_reg <= scan_blk_reg; page_reg <= {4'h0, scan_page_reg}; state_reg <= st_ptr_type;
          end else if (start_i && scanned_reg && rb2_reg) begin
            op_reg <= op_i; area_reg <= area_i; block_reg <= block_i; page_reg <= page_i;
            col_reg <= column_i; wdata_reg <= wdata_i;
            state_reg <= (op_i == op_erase_type || op_i == op_reset_type) ? st_cmd_type : st_ptr_type;
          end
        end
        st_ptr_type: if (phase_end) begin
          tick_reg <= 16'h0000;
          state_reg <= (op_reg == op_read_type || op_reg == op_scan_type) ? st_addr_type : st_cmd_type;
        end
        st_cmd_type: if (phase_end) begin
          tick_reg <= 16'h0000; addr_cnt_reg <= (op_reg == op_erase_type) ? 3'h1 : 3'h0;
          state_reg <= (op_reg == op_reset_type) ? st_wait_type : st_addr_type;
        end
        st_addr_type: if (phase_end) begin
          tick_reg <= 16'h0000; addr_cnt_reg <= addr_cnt_reg + 3'h1;
          if (addr_cnt_reg == 3'h3) begin
            addr_cnt_reg <= 3'h0;
            state_reg <= (op_reg == op_program_type) ? st_data_type :
                         (op_reg == op_erase_type) ? st_cmd2_type : st_wait_type;
            if (op_reg == op_erase_type && look_bad) begin
              // confirm withheld: a listed block is never erased
              state_reg <= st_desel_type; fail_o <= 1'b1;
            end
          end
        end
        st_data_type: if (phase_end) begin
          tick_reg <= 16'h0000; state_reg <= st_cmd2_type;
        end
        st_cmd2_type: if (phase_end) begin
          tick_reg <= 16'h0000; state_reg <= st_wait_type;
        end
        st_wait_type: begin
          // wait out LAST_OUT_TO_BUSY_CYCLES then for ready; a cell load bound guards reads
          if (tick_reg > 16'(`LAST_OUT_TO_BUSY_CYCLES) && rb2_reg) begin
            tick_reg <= 16'h0000;
            state_reg <= (op_reg == op_program_type || op_reg == op_erase_type) ? st_stat_type :
                         (op_reg == op_reset_type) ? st_desel_type : st_read_type;
          end else if (tick_reg == 16'(CELL_LOAD_CYCLES + `LAST_OUT_TO_BUSY_CYCLES) &&
                       (op_reg == op_read_type || op_reg == op_scan_type)) begin
            tick_reg <= 16'h0000; state_reg <= st_desel_type; fail_o <= 1'b1;
          end
        end
        st_stat_type: if (tick_reg == 16'(2 * `STROBE_CYCLES - 1)) begin
          tick_reg <= 16'h0000; fail_o <= sync2_reg[0]; state_reg <= st_desel_type;
          if (sync2_reg[0]) begin
            mark_reg <= 1'b1; scan_blk_reg <= block_reg;
          end
        end
        st_read_type: if (tick_reg == 16'(2 * `STROBE_CYCLES - 1)) begin
          tick_reg <= 16'h0000; rdata_o <= sync2_reg; fail_o <= 1'b0; state_reg <= st_desel_type;
          if (op_reg == op_scan_type) begin
            if (sync2_reg != `ERASED_BYTE && block_reg != '0) begin
              mark_reg <= 1'b1;
            end
          end
        end
        st_desel_type: if (tick_reg == 16'(`DESELECT_HOLD_CYCLES)) begin
          tick_reg <= 16'h0000; state_reg <= st_idle_type;
          if (op_reg == op_scan_type) begin
            scan_page_reg <= ~scan_page_reg;
            if (scan_page_reg) begin
              scan_blk_reg <= scan_blk_reg + 1'b1;
              if (&scan_blk_reg) begin
                scanned_reg <= 1'b1; scan_done_o <= 1'b1;
              end
            end
          end else begin
            done_o <= 1'b1;
          end
        end
        default: state_reg <= st_idle_type;
      endcase
    end
  end

  // ==========================================================
  // pointer record
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pointer_o <= area_first_type;
    end else if (state_reg == st_ptr_type && phase_end) begin
      pointer_o <= area_reg;
    end else if (state_reg == st_desel_type && pointer_o == area_second_type) begin
      pointer_o <= area_first_type;
    end else if (state_reg == st_cmd_type && op_reg == op_reset_type) begin
      pointer_o <= area_first_type;
    end
  end

  // ==========================================================
  // pin drive
  logic low_half;
  assign low_half = (tick_reg < 16'(`STROBE_CYCLES / 2));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      io_out_o <= 8'h00; io_oe_o <= 1'b0; cle_o <= 1'b0; ale_o <= 1'b0; chip_sel_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1; output_strobe_n_o <= 1'b1;
    end else begin
      chip_sel_n_o <= (state_reg == st_idle_type || state_reg == st_desel_type);
      cle_o <= (state_reg == st_ptr_type || state_reg == st_cmd_type || state_reg == st_cmd2_type) ||
               (state_reg == st_stat_type && tick_reg < 16'(`STROBE_CYCLES));
      ale_o <= (state_reg == st_addr_type);
      io_oe_o <= (state_reg == st_ptr_type || state_reg == st_cmd_type || state_reg == st_addr_type ||
                  state_reg == st_data_type || state_reg == st_cmd2_type) ||
                 (state_reg == st_stat_type && tick_reg < 16'(`STROBE_CYCLES));
      write_strobe_n_o <= !((state_reg == st_ptr_type || state_reg == st_cmd_type ||
                             state_reg == st_addr_type || state_reg == st_data_type ||
                             state_reg == st_cmd2_type) && low_half) &&
                          !(state_reg == st_stat_type && tick_reg < 16'(`STROBE_CYCLES / 2));
      // status read waits out the write high to output delay after the 70h strobe
      output_strobe_n_o <= !((state_reg == st_read_type && tick_reg >= 16'(`STROBE_CYCLES)) ||
                             (state_reg == st_stat_type &&
                              tick_reg >= 16'(`STROBE_CYCLES / 2 + `WE_HIGH_TO_OUT_CYCLES)));
      case (state_reg)
        st_ptr_type: io_out_o <= ptr_cmd(area_reg);
        st_cmd_type: io_out_o <= op_cmd(op_reg);
        st_addr_type: io_out_o <= addr_byte(addr_cnt_reg, col_reg, page_reg, block_reg);
        st_data_type: io_out_o <= wdata_reg;
        st_cmd2_type: io_out_o <= (op_reg == op_erase_type) ? `CMD_ERASE_START : `CMD_PROG_START;
        st_stat_type: io_out_o <= `CMD_STATUS;
        default: io_out_o <= 8'h00;
      endcase
    end
  end
endmodule // nand_host

// ==== verif/nand_host_checker_properties.sv ====
/* port checker for nand_host.
   assumes it is bound to every nand_host instance. */
module nand_host_props
  import nand_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ready_busy_i,
  input wire logic [7:0] io_out_o,
  input wire logic io_oe_o,
  input wire logic cle_o,
  input wire logic ale_o,
  input wire logic chip_sel_n_o,
  input wire logic write_strobe_n_o,
  input wire logic output_strobe_n_o,
  input wire logic done_o,
  input wire logic scan_done_o,
  input wire nand_host_pkg::area_type pointer_o
);
  logic [7:0] hi_cnt;
  logic [7:0] last_cmd;
  logic [2:0] addr_cnt;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_cnt <= 8'hFF;
      last_cmd <= 8'hFF;
      addr_cnt <= 3'h0;
    end else begin
      hi_cnt <= chip_sel_n_o ? hi_cnt + {7'h00, hi_cnt != 8'hFF} : 8'h00;
      if ($fell(write_strobe_n_o) && cle_o) begin
        last_cmd <= io_out_o;
        addr_cnt <= 3'h0;
      end else if ($fell(write_strobe_n_o) && ale_o) begin
        addr_cnt <= addr_cnt + 3'h1;
      end
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence cmd_edge;
    $fell(write_strobe_n_o) && cle_o;
  endsequence
  // ==========
  // assertions
  a_cs_hold_long: assert property ($fell(chip_sel_n_o) |-> hi_cnt >= 8'h1A)
    else $error("deselect too short");
  a_prog_after_ptr: assert property (cmd_edge ##0 io_out_o == 8'h80 |-> last_cmd inside {8'h00, 8'h01, 8'h50})
    else $error("program load without pointer");
  a_ready_before_cmd: assert property (cmd_edge ##0 !(io_out_o inside {8'h70, 8'hFF}) |-> ready_busy_i)
    else $error("command while busy");
  a_read_four_addr: assert property ($fell(output_strobe_n_o) && last_cmd inside {8'h00, 8'h01, 8'h50}
    |-> addr_cnt == 3'h4)
    else $error("read without four addresses");
  a_erase_after_scan: assert property (cmd_edge ##0 io_out_o == 8'h60 |-> scan_done_o)
    else $error("erase before scan");
  a_ptr_revert: assert property (done_o |=> pointer_o != area_second_type)
    else $error("second half pointer kept");
  a_no_bus_fight: assert property (!output_strobe_n_o |-> !io_oe_o ##1 !io_oe_o)
    else $error("driving during read");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_cle_off_read: assert property (!output_strobe_n_o |-> !cle_o && !ale_o)
    else $error("latch enable high during read");
endmodule // nand_host_props

bind nand_host nand_host_props u_props (.mclk_i, .rst_i, .ready_busy_i, .io_out_o, .io_oe_o, .cle_o, .ale_o,
  .chip_sel_n_o, .write_strobe_n_o, .output_strobe_n_o, .done_o, .scan_done_o, .pointer_o);

// ==== verif/nand_dev.sv ====
/* behavioural byte-wide nand device: pointer, page data, markers, busy.
   assumes the host drives strobes per the nand protocol. */
module nand_dev #(
  parameter int BAD_BLK = 3,
  parameter int FAIL_BLK = 5
) (
  input wire logic [7:0] io_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic cs_n_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic slow_i,
  output logic [7:0] io_o,
  output logic rb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [7:0] cmd, dout, last, wbuf;
  logic [31:0] addr;
  logic [1:0] ptr;
  logic fl;
  int na, tok;
  function automatic int key(input logic [1:0] p);
    return int'(addr[31:8]) * 1024 + (p == 2'h2 ? 512 + int'(addr[3:0]) : int'(p) * 256 + int'(addr[7:0]));
  endfunction
  task automatic go_busy(input int t_ns);
    int t;
    tok++;
    t = tok;
    rb_o = 1'b0;
    #(t_ns);
    if (t == tok) rb_o = 1'b1;
  endtask
  // released bus shows a changing pattern
  assign io_o = (!cs_n_i && !re_n_i) ? dout : ~last;
  initial begin
    rb_o = 1'b1;
    ptr = 2'h0;
    na = 0;
    tok = 0;
    fl = 1'b0;
    last = 8'h00;
    dout = 8'h00;
    cmd = 8'h00;
    addr = '0;
    wbuf = 8'hFF;
    mem[BAD_BLK * 32768 + 517] = 8'h00;
    mem[(BAD_BLK + 4) * 32768 + 1024 + 517] = 8'h00;
  end
  always @(posedge re_n_i) last = dout;
  always @(posedge cs_n_i) if (!rb_o && cmd inside {8'h00, 8'h01, 8'h50}) begin
    tok++;
    #50 rb_o = 1'b1;
  end
  always @(posedge we_n_i) if (!cs_n_i) begin
    if (cle_i) begin
      cmd = io_i;
      na = 0;
      case (io_i)
        8'h00: ptr = 2'h0;
        8'h01: ptr = 2'h1;
        8'h50: ptr = 2'h2;
        8'h70: dout = {7'h00, fl};
        8'hFF: begin
          ptr = 2'h0;
          fork go_busy(3000); join_none
        end
        8'h10, 8'hD0: begin
          fl = addr[31:13] == 19'(FAIL_BLK);
          if (!fl && io_i == 8'h10) mem[key(ptr)] = wbuf;
          if (!fl && io_i == 8'hD0) for (int k = 0; k < 32768; k++) mem.delete(int'(addr[31:13]) * 32768 + k);
          ptr = (ptr == 2'h1) ? 2'h0 : ptr;
          fork go_busy(200); join_none
        end
        default: ;
      endcase
    end else if (ale_i) begin
      addr[8 * (cmd == 8'h60 ? na + 1 : na) +: 8] = io_i;
      na++;
      if (na == 4 && cmd inside {8'h00, 8'h01, 8'h50}) begin
        dout = mem.exists(key(ptr)) ? mem[key(ptr)] : 8'hFF;
        ptr = (ptr == 2'h1) ? 2'h0 : ptr;
        fork go_busy(slow_i ? 2000 : 100); join_none
      end
    end else begin
      wbuf = io_i;
    end
  end
endmodule // nand_dev

// ==== verif/testbench.sv ====
/* self-checking bench of nand_host with the nand_dev model.
   assumes the package, params header and checker are compiled first. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nand_host_pkg::*;
  localparam int AB = 3;
  localparam int BAD = 3;
  localparam int FAILB = 5;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic slow = 1'b0;
  op_type op_i = op_read_type;
  area_type area_i = area_first_type;
  logic [AB-1:0] block_i = '0;
  logic [4:0] page_i = 5'h00;
  logic [7:0] column_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] io_in_i, io_out_o, rdata_o, c, d;
  logic ready_busy_i, io_oe_o, cle_o, ale_o, chip_sel_n_o, write_strobe_n_o, output_strobe_n_o;
  logic done_o, fail_o, block_bad_o, scan_done_o;
  area_type pointer_o;
  logic [10:0] q[$];
  logic [10:0] e;
  int num_errors = 0;
  int n_checks = 0;
  always #2 mclk_i = ~mclk_i;
  nand_host #(.ABITS(AB), .CELL_LOAD_CYCLES(50)) DUT (.mclk_i, .rst_i, .start_i, .op_i, .area_i, .block_i,
    .page_i, .column_i, .wdata_i, .io_in_i, .ready_busy_i, .io_out_o, .io_oe_o, .cle_o, .ale_o, .chip_sel_n_o,
    .write_strobe_n_o, .output_strobe_n_o, .rdata_o, .done_o, .fail_o, .block_bad_o, .scan_done_o, .pointer_o);
  nand_dev #(.BAD_BLK(BAD), .FAIL_BLK(FAILB)) flash (.io_i(io_out_o), .cle_i(cle_o), .ale_i(ale_o),
    .cs_n_i(chip_sel_n_o), .we_n_i(write_strobe_n_o), .re_n_i(output_strobe_n_o), .slow_i(slow),
    .io_o(io_in_i), .rb_o(ready_busy_i));
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // note: {check data, check fail, fail, data}
  task automatic run(input op_type o, input area_type a, input int b, input int p, input logic [7:0] col,
                     input logic [7:0] dat, input logic [10:0] note);
    int i;
    op_i = o;
    area_i = a;
    block_i = AB'(b);
    page_i = 5'(p);
    column_i = col;
    wdata_i = dat;
    start_i = 1'b1;
    q.push_back(note);
    for (i = 0; i < 4000; i++) begin
      @(posedge mclk_i);
      #1;
      if (done_o === 1'b1) break;
    end
    start_i = 1'b0;
    if (i == 4000) begin
      num_errors++;
      $display("FAIL %0t no done", $time);
      stop_test();
    end
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic bad_is(input int b, input logic exp);
    block_i = AB'(b);
    repeat (3) @(posedge mclk_i);
    #1;
    cmp({7'h00, block_bad_o}, {7'h00, exp});
  endtask
  always @(negedge mclk_i) if (done_o === 1'b1) begin
    if (q.size() == 0) begin
      num_errors++;
      $display("FAIL %0t unexpected done", $time);
    end else begin
      e = q.pop_front();
      if (e[9]) cmp({7'h00, fail_o}, {7'h00, e[8]});
      if (e[10]) cmp(rdata_o, e[7:0]);
    end
  end
  initial begin
    int w;
    void'($urandom(74643));
    repeat (6) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    for (w = 0; w < 20000 && scan_done_o !== 1'b1; w++) @(posedge mclk_i);
    #1;
    if (w == 20000) begin
      num_errors++;
      $display("FAIL %0t scan hung", $time);
      stop_test();
    end
    for (w = 0; w < 8; w++) bad_is(w, w == BAD || w == BAD + 4);
    c = $urandom;
    d = $urandom;
    run(op_read_type, area_first_type, 1, 2, c, 8'h00, {3'b101, 8'hFF});
    run(op_program_type, area_second_type, 1, 2, c, d, {3'b010, 8'h00});
    cmp({6'h00, pointer_o}, {6'h00, area_first_type});
    run(op_read_type, area_second_type, 1, 2, c, 8'h00, {3'b100, d});
    run(op_read_type, area_first_type, 1, 2, c, 8'h00, {3'b100, 8'hFF});
    run(op_program_type, area_spare_type, 2, 0, {4'h0, c[3:0]}, ~d, {3'b010, 8'h00});
    run(op_read_type, area_spare_type, 2, 0, {4'h0, c[3:0]}, 8'h00, {3'b100, ~d});
    cmp({6'h00, pointer_o}, {6'h00, area_spare_type});
    for (w = 0; w < 4; w++) begin
      c = $urandom;
      d = $urandom;
      run(op_program_type, area_first_type, 6, 8 + w, c, d, {3'b010, 8'h00});
      run(op_read_type, area_first_type, 6, 8 + w, c, 8'h00, {3'b101, d});
    end
    run(op_erase_type, area_first_type, 6, 0, 8'h00, 8'h00, {3'b010, 8'h00});
    run(op_read_type, area_first_type, 6, 11, c, 8'h00, {3'b100, 8'hFF});
    run(op_program_type, area_first_type, FAILB, 1, c, d, {3'b011, 8'h00});
    bad_is(FAILB, 1'b1);
    run(op_erase_type, area_first_type, BAD, 0, 8'h00, 8'h00, {3'b011, 8'h00});
    run(op_read_type, area_spare_type, BAD, 0, 8'h05, 8'h00, {3'b100, 8'h00});
    run(op_reset_type, area_first_type, 1, 0, 8'h00, 8'h00, 11'h000);
    slow = 1'b1;
    run(op_read_type, area_first_type, 1, 3, c, 8'h00, {3'b011, 8'h00});
    slow = 1'b0;
    run(op_read_type, area_first_type, 6, 12, c, 8'h00, {3'b110, 8'hFF});
    stop_test();
  end
endmodule // testbench
